/* File: hdl/dttc_ctrl.v */
// Toggle mode and thermal shutdown control for a 32-channel converter.
//
// The strobed register port and the register offsets were left to the implementer.
`timescale 1ns/1ps
`include "dttc_defs.vh"
module dttc_ctrl #(
   parameter NCH = 32,
   parameter DW = 14
) (
   input wire clk,
   input wire sys_rst,
   input wire host_wr,
   input wire [1:0] host_sel,
   input wire [4:0] channel_address_field,
   input wire [15:0] host_data,
   input wire output_update_strobe,
   input wire over_temp,
   input wire soft_power_up,
   input wire [3:0] reg_addr,
   input wire [15:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output reg [15:0] reg_rdata,
   output reg [NCH*DW-1:0] dac_out,
   output reg amp_power_down,
   output wire irq
);
   // ***********************************************************
   // Storage and synchronised inputs
   // ***********************************************************
   reg [DW-1:0] data_a [0:NCH-1];
   reg [DW-1:0] data_b [0:NCH-1];
   reg [15:0] ctrl;
   reg [NCH-1:0] src_b;
   reg shut_latch;
   reg [2:0] irq_stat;
   reg [2:0] irq_mask;
   reg strobe_d;
   wire strobe_s;
   wire temp_s;
   wire [3:0] tog_en;
   wire toggle_group3_enable;
   wire toggle_group2_enable;
   wire toggle_group1_enable;
   wire toggle_group0_enable;
   wire thermal_guard_enable;
   wire strobe_edge;
   wire ctrl_wr;
   wire b_wr;
   wire b_ok;
   wire ctrl_sw_wr;
   wire [15:0] ctrl_wval;
   integer i;
   integer j;

   dttc_sync u_sync_strobe (
      .clk(clk),
      .sys_rst(sys_rst),
      .async_in(output_update_strobe),
      .sync_out(strobe_s)
   );

   dttc_sync u_sync_temp (
      .clk(clk),
      .sys_rst(sys_rst),
      .async_in(over_temp),
      .sync_out(temp_s)
   );

   // ***********************************************************
   // Decode
   // ***********************************************************
   // The strobe is active low; the update happens on its falling edge.
   assign strobe_edge = strobe_d & ~strobe_s;
   assign ctrl_wr = host_wr && (host_sel == `DTTC_SEL_DATA) &&
                    (channel_address_field == `DTTC_CTRL_ADDR);
   assign b_wr = host_wr && (host_sel == `DTTC_SEL_B);
   assign tog_en = ctrl[`DTTC_CR_TOG_HI:`DTTC_CR_TOG_LO];
   assign toggle_group3_enable = tog_en[3];
   assign toggle_group2_enable = tog_en[2];
   assign toggle_group1_enable = tog_en[1];
   assign toggle_group0_enable = tog_en[0];
   assign thermal_guard_enable = ctrl[`DTTC_CR_THERM];
   // Groups of eight channels share one enable bit.
   assign b_ok = tog_en[channel_address_field[4:3]];
   assign ctrl_sw_wr = reg_wr && (reg_addr == `DTTC_OFS_CTRL);
   // A host pin write takes priority over a software write in the same cycle.
   assign ctrl_wval = ctrl_wr ? host_data : reg_wdata;
   assign irq = |(irq_stat & irq_mask);

   // ***********************************************************
   // Data registers
   // ***********************************************************
   // Address 01100 with select zero is the control register, so no A load there.
   // Channel 12 can never load its A register, so the arrays are cleared
   // while reset is held; otherwise that channel would show an unknown code.
   always @(posedge clk) begin
      if (sys_rst) begin
         for (j = 0; j < NCH; j = j + 1) begin
            data_a[j] <= {DW{1'b0}};
            data_b[j] <= {DW{1'b0}};
         end
      end else begin
         if (host_wr && (host_sel == `DTTC_SEL_DATA) && !ctrl_wr) begin
            data_a[channel_address_field] <= host_data[DW-1:0];
         end
         if (b_wr && b_ok) begin
            data_b[channel_address_field] <= host_data[DW-1:0];
         end
      end
   end

   // ***********************************************************
   // Control register and output source selection
   // ***********************************************************
   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         ctrl <= `DTTC_CR_RESET;
         // The synchroniser leaves reset low, so a high start here would fake a falling edge.
         strobe_d <= 1'b0;
         src_b <= {NCH{1'b0}};
         dac_out <= {NCH*DW{1'b0}};
      end else begin
         strobe_d <= strobe_s;
         if (ctrl_wr || ctrl_sw_wr) begin
            ctrl <= ctrl_wval;
         end
         if (strobe_edge) begin
            for (i = 0; i < NCH; i = i + 1) begin
               // Source flag says which register the next strobe shows.
               if (tog_en[i/8]) begin
                  dac_out[i*DW +: DW] <= src_b[i] ? data_b[i] : data_a[i];
                  src_b[i] <= ~src_b[i];
               end else begin
                  dac_out[i*DW +: DW] <= data_a[i];
                  src_b[i] <= 1'b0;
               end
            end
         end else begin
            for (i = 0; i < NCH; i = i + 1) begin
               // Disabling a group rearms it so its first strobe shows A.
               if (!tog_en[i/8]) begin
                  src_b[i] <= 1'b0;
               end
            end
         end
      end
   end

   // ***********************************************************
   // Thermal shutdown latch
   // ***********************************************************
   // Soft power-up wins only when the die is cool; a hot die keeps the latch set unless bit eight is cleared.
   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         shut_latch <= 1'b0;
      end else if (!thermal_guard_enable) begin
         shut_latch <= 1'b0;
      end else if (temp_s) begin
         shut_latch <= 1'b1;
      end else if (soft_power_up) begin
         shut_latch <= 1'b0;
      end
   end

   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         amp_power_down <= 1'b0;
      end else begin
         amp_power_down <= shut_latch;
      end
   end

   // ***********************************************************
   // Interrupt status and register reads
   // ***********************************************************
   // A new event in the clearing cycle keeps its bit set.
   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         irq_stat <= 3'h0;
         irq_mask <= 3'h0;
      end else begin
         if (reg_wr && (reg_addr == `DTTC_OFS_MASK)) begin
            irq_mask <= reg_wdata[2:0];
         end
         irq_stat <= (irq_stat & ~((reg_wr && (reg_addr == `DTTC_OFS_IRQ)) ? reg_wdata[2:0] : 3'h0))
                     | {b_wr & ~b_ok, strobe_edge, temp_s & thermal_guard_enable & ~shut_latch};
      end
   end

   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         reg_rdata <= 16'h0000;
      end else if (reg_rd) begin
         case (reg_addr)
            `DTTC_OFS_CTRL: reg_rdata <= ctrl;
            `DTTC_OFS_STAT: reg_rdata <= {14'h0000, temp_s, shut_latch};
            `DTTC_OFS_IRQ: reg_rdata <= {13'h0000, irq_stat};
            `DTTC_OFS_MASK: reg_rdata <= {13'h0000, irq_mask};
            default: reg_rdata <= 16'h0000;
         endcase
      end else begin
         reg_rdata <= 16'h0000;
      end
   end
endmodule // dttc_ctrl

/* File: hdl/dttc_defs.vh */
// Constants and bit positions for the toggle and thermal control block.
//
// Contract
// - Select bits zero, address 01100: control write
// - Bits five to two enable toggle groups
// - Every channel holds an A and B register
// - B loads only in toggle-enabled groups
// - Strobe alternates source; first strobe picks A
// - Output flips once per update strobe
// - Clearing group bits stops toggling
// - First strobe after disable loads A
// - Thermal shutdown only while bit eight set
// - Over-temperature powers down all amplifiers
// - Stay off until soft power-up or disable
`ifndef DTTC_DEFS_VH
`define DTTC_DEFS_VH
// Address of the control register among the channel address codes.
`define DTTC_CTRL_ADDR 5'h0c
// Register select code that marks a data or control write.
`define DTTC_SEL_DATA 2'h0
// Register select code that marks a write to a B register.
`define DTTC_SEL_B 2'h1
// Control register field positions.
`define DTTC_CR_TOG_LO 2
`define DTTC_CR_TOG_HI 5
`define DTTC_CR_THERM 8
`define DTTC_CR_RESET 16'h0000
// Software register offsets on the plain port.
`define DTTC_OFS_CTRL 4'h0
`define DTTC_OFS_STAT 4'h1
`define DTTC_OFS_IRQ 4'h2
`define DTTC_OFS_MASK 4'h3
// Interrupt status bit positions.
`define DTTC_IRQ_SHUT 0
`define DTTC_IRQ_STROBE 1
`define DTTC_IRQ_BREJ 2
`endif

/* File: hdl/dttc_sync.v */
// Two-stage synchroniser for one asynchronous input level.
`timescale 1ns/1ps
module dttc_sync (
   input wire clk,
   input wire sys_rst,
   input wire async_in,
   output reg sync_out
);
   reg stage1;

   // First stage feeds only the second stage.
   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         stage1 <= 1'b0;
         sync_out <= 1'b0;
      end else begin
         stage1 <= async_in;
         sync_out <= stage1;
      end
   end
endmodule // dttc_sync

/* File: tb/dttc_chk.sv */
// Checker for the toggle and thermal control block.
`timescale 1ns/1ps
module dttc_chk #(parameter NCH = 32, parameter DW = 14) (
   input wire clk,
   input wire sys_rst,
   input wire host_wr,
   input wire output_update_strobe,
   input wire over_temp,
   input wire reg_wr,
   input wire reg_rd,
   input wire [15:0] reg_rdata,
   input wire [NCH*DW-1:0] dac_out,
   input wire amp_power_down,
   input wire irq
);
   reg [3:0] hot, wr, fall;
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   // Ages of each cause; they saturate so a stale cause excuses nothing.
   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         {hot, wr, fall} <= 12'hfff;
      end else begin
         hot <= over_temp ? 4'h0 : hot + {3'h0, ~&hot};
         wr <= (host_wr | reg_wr) ? 4'h0 : wr + {3'h0, ~&wr};
         fall <= $fell(output_update_strobe) ? 4'h0 : fall + {3'h0, ~&fall};
      end
   end
   rd_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000) else $error("stray data");
   pd_cause_a: assert property ($rose(amp_power_down) |-> hot < 8) else $error("cold off");
   pd_hold_a: assert property (over_temp [*6] ##0 (amp_power_down && wr > 7) |=> amp_power_down) else $error("hot on");
   pd_fall_a: assert property ($fell(amp_power_down) |-> wr < 8 || hot > 1) else $error("warm on");
   dac_when_a: assert property ($changed(dac_out) |-> fall < 6) else $error("no strobe");
   dac_once_a: assert property ($changed(dac_out) |=> $stable(dac_out) [*3]) else $error("twice");
   irq_rise_a: assert property ($rose(irq) |-> wr < 4 || fall < 6 || hot < 8) else $error("irq no event");
   irq_fall_a: assert property ($fell(irq) |-> wr < 2) else $error("irq no write");
   cover property ($rose(amp_power_down));
   cover property ($fell(amp_power_down) && hot > 7);
   cover property ($changed(dac_out));
endmodule // dttc_chk
bind dttc_ctrl dttc_chk #(.NCH(NCH), .DW(DW)) i_chk (.*);

/* File: tb/dttc_host.sv */
// Host model: pin writes and the update strobe.
`timescale 1ns/1ps
module dttc_host (
   input wire clk,
   output reg host_wr = 1'h0,
   output reg [1:0] host_sel = 2'h0,
   output reg [4:0] channel_address_field = 5'h00,
   output reg [15:0] host_data = 16'h0000,
   output reg output_update_strobe = 1'h1
);
   // One-cycle write; released data is inverted so stale data never passes.
   task wr(input [1:0] s, input [4:0] a, input [15:0] d);
      @(posedge clk);
      host_sel <= s;
      channel_address_field <= a;
      host_data <= d;
      host_wr <= 1'h1;
      @(posedge clk);
      host_wr <= 1'h0;
      host_data <= ~d;
   endtask
   // Strobe low six cycles, high four; longer than the sync needs.
   task strobe;
      output_update_strobe <= 1'h0;
      repeat (6) @(posedge clk);
      output_update_strobe <= 1'h1;
      repeat (4) @(posedge clk);
   endtask
endmodule // dttc_host

/* File: tb/dttc_ctrl_test.sv */
// Self-checking bench for the toggle and thermal block.
`timescale 1ns/1ps
module dttc_ctrl_test;
   reg clk = 1'h0, sys_rst = 1'h1, over_temp = 1'h0, soft_power_up = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0;
   reg [3:0] reg_addr = 4'h0;
   reg [15:0] reg_wdata = 16'h0000, i, k;
   wire host_wr, output_update_strobe, amp_power_down, irq;
   wire [1:0] host_sel;
   wire [4:0] channel_address_field;
   wire [15:0] host_data, reg_rdata;
   wire [447:0] dac_out;
   integer error_cnt = 0, num_checks = 0;
   dttc_ctrl i_dut (.*);
   dttc_host i_host (.*);
   // System clock, 20 ns.
   initial forever #10 clk = ~clk;
   // Compare and count.
   task chk(input string n, input [15:0] e, input [15:0] s);
      num_checks++;
      if (s !== e) begin
         error_cnt++;
         $display("mismatch %s exp %h got %h", n, e, s);
      end
   endtask
   // One register access; a read checks its data in the next cycle.
   task acc(input rd, input [3:0] a, input [15:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_rd <= rd;
      reg_wr <= !rd;
      @(posedge clk);
      reg_rd <= 1'h0;
      reg_wr <= 1'h0;
      #1;
      if (rd)
         chk("rdata", d, reg_rdata);
   endtask
   // Let the thermal path settle first.
   task pd(input [15:0] e);
      repeat (12) @(posedge clk);
      chk("amp", e, {15'h0000, amp_power_down});
   endtask
   task stop_test;
      $display("checks %0d mismatches %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // Channel 12 has no A write: its address with select zero is control.
   initial begin
      repeat (6) @(posedge clk);
      sys_rst <= 1'h0;
      i_host.wr(2'h0, 5'h0c, 16'h0014);
      acc(1, 4'h0, 16'h0014);
      acc(1, 4'h7, 16'h0000);
      for (i = 0; i < 64; i++)
         if (i != 12)
            i_host.wr({1'h0, i[5]}, i[4:0], {i[5] ? 8'h20 : 8'h01, 3'h0, i[4:0]});
      for (k = 0; k < 6; k++) begin
         if (k == 4)
            i_host.wr(2'h0, 5'h0c, 16'h0000);
         i_host.strobe;
         for (i = 0; i < 32; i++)
            if (i != 12)
               chk("dac", {k[0] && k < 4 && !i[3] ? 8'h20 : 8'h01, 3'h0, i[4:0]}, {2'h0, dac_out[i*14 +: 14]});
      end
      acc(1, 4'h2, 16'h0006);
      acc(0, 4'h3, 16'h0004);
      chk("irq", 16'h0001, {15'h0000, irq});
      acc(0, 4'h2, 16'h0006);
      chk("irq", 16'h0000, {15'h0000, irq});
      over_temp <= 1'h1;
      pd(16'h0000);
      acc(0, 4'h0, 16'h0100);
      pd(16'h0001);
      acc(1, 4'h1, 16'h0003);
      over_temp <= 1'h0;
      pd(16'h0001);
      soft_power_up <= 1'h1;
      pd(16'h0000);
      soft_power_up <= 1'h0;
      over_temp <= 1'h1;
      pd(16'h0001);
      acc(0, 4'h0, 16'h0000);
      pd(16'h0000);
      stop_test;
   end
endmodule // dttc_ctrl_test
